// ### spp_pkg.sv
// Functional notes
// - mask read command returns interrupt masks
// - mask read also returns pending, input level
// - mask set command acts on data bits
// - bits 3 or 4 update masks
// - bit 6 drives output pin from data
// - mask and output updates are independent
// - one means high pin, zero low
// - bit 6 zero keeps output level
// - output pin low after reset
// - mask read leaves sign flag alone
// - start zero, eight data bits lsb first
// - one or more stop bits, two at 110; the code sends two only when STAT bit 0 is set, at any rate, and one otherwise
// - line idles high between frames
// - equal bit cells of one period
// - rates from 110 to 9600 baud
// - rate learned from received space character
// - store full and half bit periods
// - transmit cells timed by full period
// - receive uses half and full periods
// - rates follow measurement, not core clock
// - output level taken from data bit 7
// - input level read back in bit 7
// - first sample one and half periods after edge
package spp_pkg;
    // ******************************************
    // register map
    // ******************************************
    localparam logic [3:0] SPP_MASK_ADDR = 4'h0;
    localparam logic [3:0] SPP_CTRL_ADDR = 4'h1;
    localparam logic [3:0] SPP_STAT_ADDR = 4'h2;
    localparam logic [3:0] SPP_TXD_ADDR = 4'h3;
    localparam logic [3:0] SPP_RXD_ADDR = 4'h4;
    localparam logic [3:0] SPP_FULL_ADDR = 4'h5;
    localparam logic [3:0] SPP_HALF_ADDR = 4'h6;
    localparam logic [7:0] SPP_MASK_READ_OP = 8'h20;
    localparam logic [7:0] SPP_MASK_SET_OP = 8'h30;
    localparam logic [7:0] SPP_SPACE_CODE = 8'h20;
    localparam int SPP_MSE_BIT = 3;
    localparam int SPP_R75_BIT = 4;
    localparam int SPP_SOE_BIT = 6;
    localparam int SPP_OUT_LVL_BIT = 7;
    localparam int SPP_CLK_MHZ = 100;
    localparam int SPP_MIN_BAUD = 110;
    // 100e6/110 = 909091 cycles; 20 bits
    localparam int SPP_PER_W = 20;
    // six low cells of a 110 baud space: 5454546 cycles, 23 bits
    localparam int SPP_MEAS_W = SPP_PER_W + 3;
    localparam int SPP_LOW_CELLS = 6;
    localparam int SPP_HALF_DIV = 12;
    localparam int SPP_STOP_110 = 2;
    localparam logic [3:0] SPP_TX_BITS = 4'hb;
    localparam logic [3:0] SPP_RX_BITS = 4'h9;
    localparam logic [2:0] SPP_MASK_RST = 3'h7;

    typedef enum logic [1:0] {SPP_RI_IDLE, SPP_RI_LOW, SPP_RI_HIGH, SPP_RI_LOW2} spp_ri_e;
    typedef enum logic [1:0] {SPP_RX_IDLE, SPP_RX_WAIT, SPP_RX_SHIFT} spp_rx_e;

    typedef struct packed {
        logic [SPP_PER_W-1:0] cnt;
        logic done;
    } spp_tmr_s;
endpackage

// ### spp_timer.sv
`timescale 1ns/10ps
// down counter, fires done when a loaded period expires
module spp_timer import spp_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [SPP_PER_W-1:0] period,
    // status
    output logic done
);
    spp_tmr_s s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (load) begin
            // one less so done lands exactly period cycles on; a period of one never fires, zero wraps to the full count
            s_d.cnt = period - 1'b1;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
            if (s_q.cnt == {{(SPP_PER_W-1){1'b0}}, 1'b1}) begin
                s_d.done = 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign done = s_q.done;
endmodule

// ### spp_top.sv
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module spp_top import spp_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial pins
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    // interrupt pins seen by the mask read
    input wire logic [2:0] irq_pending
);
    // ******************************************
    // state
    // ******************************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic out_lvl;
        logic [2:0] mask;
        logic [7:0] acc;
        logic rx_prev;
        spp_ri_e ri;
        logic [SPP_MEAS_W-1:0] meas;
        logic [SPP_PER_W-1:0] full;
        logic [SPP_PER_W-1:0] half;
        logic rate_ok;
        logic ri_req;
        logic tx_busy;
        logic [3:0] tx_cnt;
        logic [8:0] tx_sh;
        logic two_stop;
        spp_rx_e rx;
        logic [3:0] rx_cnt;
        logic [7:0] rx_sh;
        logic [7:0] rx_data;
        logic rx_valid;
    } spp_state_s;

    spp_state_s s_q, s_d;
    logic tx_load, rx_load, tx_done, rx_done;
    logic [SPP_PER_W-1:0] rx_period;
    logic wr, rd;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack && wb_sel_i[0];
    assign rd = wb_cyc_i && wb_stb_i && !s_q.ack;

    spp_timer u_tx_tmr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(tx_load),
        .period(s_q.full),
        .done(tx_done)
    );
    spp_timer u_rx_tmr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(rx_load),
        .period(rx_period),
        .done(rx_done)
    );

    always_comb begin
        s_d = s_q;
        tx_load = 1'b0;
        rx_load = 1'b0;
        rx_period = s_q.full;
        s_d.ack = rd;
        s_d.rx_prev = serial_in_pin;
        // ******************************************
        // register writes and commands
        // ******************************************
        if (wr) begin
            case (wb_adr_i)
                SPP_CTRL_ADDR: begin
                    if (wb_dat_i[7:0] == SPP_MASK_SET_OP) begin
                        // each half acts on its own enable bit
                        if (s_q.acc[SPP_MSE_BIT] || s_q.acc[SPP_R75_BIT]) begin
                            s_d.mask = s_q.acc[2:0];
                        end
                        if (s_q.acc[SPP_SOE_BIT]) begin
                            s_d.out_lvl = s_q.acc[SPP_OUT_LVL_BIT];
                        end
                    end else if (wb_dat_i[7:0] == SPP_MASK_READ_OP) begin
                        s_d.acc = {serial_in_pin, irq_pending, 1'b0, s_q.mask};
                    end
                    if (wb_dat_i[8]) begin
                        s_d.ri_req = 1'b1; // re-measure on request
                        s_d.rate_ok = 1'b0;
                    end
                    if (wb_dat_i[9] && s_q.rate_ok && !s_q.tx_busy) begin
                        s_d.tx_busy = 1'b1;
                        s_d.tx_cnt = s_q.two_stop ? SPP_TX_BITS : SPP_TX_BITS - 4'h1;
                        s_d.tx_sh = {s_q.acc, 1'b0}; // start bit first
                        tx_load = 1'b1;
                    end
                end
                SPP_MASK_ADDR: s_d.acc = wb_dat_i[7:0];
                SPP_STAT_ADDR: s_d.two_stop = wb_dat_i[0];
                default: ;
            endcase
        end
        if (rd && !wb_we_i && wb_adr_i == SPP_RXD_ADDR) begin
            s_d.rx_valid = 1'b0;
        end
        // ******************************************
        // rate identification
        // ******************************************
        // meas holds six 110 baud cells at 100 MHz
        case (s_q.ri)
            SPP_RI_IDLE: begin
                if (s_q.ri_req && s_q.rx_prev && !serial_in_pin) begin
                    s_d.ri = SPP_RI_LOW;
                    s_d.meas = '0;
                end
            end
            SPP_RI_LOW: begin
                // space is 0 then 00000100: start+5 low bits measured
                s_d.meas = s_q.meas + 1'b1;
                if (serial_in_pin) begin
                    s_d.ri = SPP_RI_HIGH;
                end
            end
            SPP_RI_HIGH: begin
                if (!serial_in_pin) begin
                    s_d.ri = SPP_RI_LOW2;
                end
            end
            SPP_RI_LOW2: begin
                if (serial_in_pin) begin // 6 low cells give period
                    s_d.full = SPP_PER_W'(s_q.meas / SPP_LOW_CELLS);
                    s_d.half = SPP_PER_W'(s_q.meas / SPP_HALF_DIV);
                    s_d.rate_ok = 1'b1;
                    s_d.ri_req = 1'b0;
                    s_d.ri = SPP_RI_IDLE;
                end
            end
            default: s_d.ri = SPP_RI_IDLE;
        endcase
        // ******************************************
        // transmitter
        // ******************************************
        if (s_q.tx_busy) begin
            s_d.out_lvl = s_q.tx_sh[0];
            if (tx_done) begin
                s_d.tx_sh = {1'b1, s_q.tx_sh[8:1]}; // idle high tail
                s_d.tx_cnt = s_q.tx_cnt - 4'h1;
                if (s_q.tx_cnt == 4'h1) begin
                    s_d.tx_busy = 1'b0;
                end else begin
                    tx_load = 1'b1;
                end
            end
        end
        // ******************************************
        // receiver
        // ******************************************
        case (s_q.rx)
            SPP_RX_IDLE: begin
                if (s_q.rate_ok && s_q.rx_prev && !serial_in_pin) begin
                    rx_period = s_q.half;
                    rx_load = 1'b1;
                    s_d.rx = SPP_RX_WAIT;
                    s_d.rx_cnt = SPP_RX_BITS;
                end
            end
            SPP_RX_WAIT: begin
                if (rx_done) begin
                    rx_load = 1'b1;
                    s_d.rx = SPP_RX_SHIFT;
                end
            end
            SPP_RX_SHIFT: begin
                if (rx_done) begin
                    s_d.rx_cnt = s_q.rx_cnt - 4'h1;
                    if (s_q.rx_cnt == 4'h1) begin
                        s_d.rx_data = s_q.rx_sh;
                        s_d.rx_valid = 1'b1;
                        s_d.rx = SPP_RX_IDLE;
                    end else begin
                        s_d.rx_sh = {serial_in_pin, s_q.rx_sh[7:1]};
                        rx_load = 1'b1;
                    end
                end
            end
            default: s_d.rx = SPP_RX_IDLE;
        endcase
        // ******************************************
        // read data
        // ******************************************
        case (wb_adr_i)
            SPP_MASK_ADDR: s_d.rdat = {24'h0, s_q.acc};
            SPP_STAT_ADDR: s_d.rdat = {26'h0, s_q.rx_valid, s_q.tx_busy,
                                       s_q.rate_ok, s_q.ri_req, s_q.out_lvl, s_q.two_stop};
            SPP_RXD_ADDR: s_d.rdat = {24'h0, s_q.rx_data};
            SPP_FULL_ADDR: s_d.rdat = {{(32-SPP_PER_W){1'b0}}, s_q.full};
            SPP_HALF_ADDR: s_d.rdat = {{(32-SPP_PER_W){1'b0}}, s_q.half};
            default: s_d.rdat = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0; // output low
            s_q.mask <= SPP_MASK_RST;
            s_q.rx_prev <= 1'b1;
            s_q.ri_req <= 1'b1; // measure after reset
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign serial_out_pin = s_q.out_lvl;
endmodule

// ### spp_asserts.sv
`timescale 1ns/10ps
module spp_asserts import spp_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pin
    input wire logic serial_out_pin
);
    default clocking @(posedge sys_clk); endclocking
    logic [7:0] acc_q;
    logic ok_q;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire ctl = take && wb_we_i && wb_adr_i == SPP_CTRL_ADDR;
    wire wr_set = ctl && ok_q && wb_dat_i[9:0] == {2'h0, SPP_MASK_SET_OP};
    // image of the accumulator, lost once the design loads it itself
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_q <= 8'h00;
            ok_q <= 1'b1;
        end else if (take && wb_we_i && wb_adr_i == SPP_MASK_ADDR) begin
            acc_q <= wb_dat_i[7:0];
            ok_q <= 1'b1;
        end else if (ctl && wb_dat_i[9:0] != {2'h0, SPP_MASK_SET_OP}) begin
            ok_q <= 1'b0;
        end
    end
    AST_RST_OUT: assert property (!rst_n |=> !serial_out_pin)
        else $error("out pin not low in reset");
    AST_RST_BUS: assert property (!rst_n |=> !wb_ack_o && wb_dat_o == 32'h0)
        else $error("bus outputs not cleared in reset");
    AST_ACK_LAT: assert property (disable iff (!rst_n) take |=> wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_ONE: assert property (disable iff (!rst_n) wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_NO_REQ: assert property (disable iff (!rst_n) !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    AST_SET_OUT: assert property (disable iff (!rst_n)
        wr_set && acc_q[SPP_SOE_BIT] |=> serial_out_pin == $past(acc_q[SPP_OUT_LVL_BIT]))
        else $error("out pin not taken from bit 7");
    AST_KEEP_OUT: assert property (disable iff (!rst_n)
        wr_set && !acc_q[SPP_SOE_BIT] |=> $stable(serial_out_pin))
        else $error("out pin moved with enable low");
    AST_RD_UNMAP: assert property (disable iff (!rst_n)
        take && !wb_we_i && wb_adr_i > SPP_HALF_ADDR |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    cover property (wr_set);
    cover property (take && !wb_we_i && wb_adr_i > SPP_HALF_ADDR);
    cover property (ctl && wb_dat_i[9]);
endmodule

// ### spp_term.sv
`timescale 1ns/10ps
module spp_term (
    // link pins
    input wire logic sys_clk,
    input wire logic serial_out_pin,
    output logic serial_in_pin
);
    initial serial_in_pin = 1'b1;
    // p cycles per cell, start low, lsb first, one stop then idle high
    task automatic send(input logic [7:0] b, input int p);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            serial_in_pin <= f[i];
            repeat (p - 1) @(posedge sys_clk);
        end
    endtask
    // returns {stop, data}; ends half a cell after the first stop cell
    task automatic recv(input int p, output logic [8:0] b);
        @(negedge serial_out_pin);
        repeat (p + p / 2) @(posedge sys_clk);
        for (int i = 0; i < 9; i++) begin
            b[i] = serial_out_pin;
            repeat (p) @(posedge sys_clk);
        end
    endtask
endmodule

// ### tb.sv
`timescale 1ns/10ps
module tb import spp_pkg::*; ();
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, serial_out_pin, serial_in_pin;
    logic [8:0] rx;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    initial forever #5 sys_clk = ~sys_clk;
    spp_top u_spp_top (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .irq_pending(3'h5));
    spp_term u_spp_term (.sys_clk(sys_clk), .serial_out_pin(serial_out_pin),
        .serial_in_pin(serial_in_pin));
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails = fails + 1;
            summarize();
        end
    end
    task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1) @(posedge sys_clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] a, input logic [31:0] c);
        xfer(SPP_MASK_ADDR, 1'b1, {24'h0, a});
        xfer(SPP_CTRL_ADDR, 1'b1, c);
        @(posedge sys_clk);
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count = check_count + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // measured periods may shift by a cycle through the input sync
    task automatic near(input logic [31:0] g, input logic [31:0] e);
        check_count = check_count + 1;
        if (g !== e && g !== e - 1 && g !== e + 1) begin
            fails = fails + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tx(input int p, input logic [8:0] e, input logic busy);
        fork
            u_spp_term.recv(p, rx);
            xfer(SPP_CTRL_ADDR, 1'b1, 32'h200);
        join
        cmp({23'h0, rx}, {23'h0, e});
        xfer(SPP_STAT_ADDR, 1'b0, 32'h0);
        cmp({31'h0, rd[4]}, {31'h0, busy});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        cmp({31'h0, serial_out_pin}, 32'h0);
        cmd(8'hc0, 32'h30);
        cmp({31'h0, serial_out_pin}, 32'h1);
        cmd(8'h08, 32'h30);
        cmp({31'h0, serial_out_pin}, 32'h1);
        cmd(8'h00, 32'h20);
        xfer(SPP_MASK_ADDR, 1'b0, 32'h0);
        cmp(rd, 32'hd0);
        cmd(8'h15, 32'h30);
        cmd(8'h00, 32'h20);
        xfer(SPP_MASK_ADDR, 1'b0, 32'h0);
        cmp(rd, 32'hd5);
        cmd(8'h40, 32'h30);
        cmp({31'h0, serial_out_pin}, 32'h0);
        xfer(4'hf, 1'b1, 32'hff);
        xfer(4'hf, 1'b0, 32'h0);
        cmp(rd, 32'h0);
        xfer(SPP_CTRL_ADDR, 1'b1, 32'h200);
        xfer(SPP_STAT_ADDR, 1'b0, 32'h0);
        cmp(rd, 32'h4);
        $display("test masks done");
        u_spp_term.send(SPP_SPACE_CODE, 200);
        xfer(SPP_FULL_ADDR, 1'b0, 32'h0);
        near(rd, 32'd200);
        xfer(SPP_HALF_ADDR, 1'b0, 32'h0);
        near(rd, 32'd100);
        $display("test rate done");
        cmd(8'hc0, 32'h30);
        xfer(SPP_MASK_ADDR, 1'b1, 32'ha5);
        tx(200, 9'h1a5, 1'b0);
        xfer(SPP_STAT_ADDR, 1'b1, 32'h1);
        tx(200, 9'h1a5, 1'b1);
        $display("test transmit done");
        u_spp_term.send(8'h3c, 200);
        xfer(SPP_STAT_ADDR, 1'b0, 32'h0);
        cmp(rd, 32'h2b);
        xfer(SPP_RXD_ADDR, 1'b0, 32'h0);
        cmp({24'h0, rd[7:0]}, 32'h3c);
        xfer(SPP_STAT_ADDR, 1'b0, 32'h0);
        cmp({31'h0, rd[5]}, 32'h0);
        $display("test receive done");
        xfer(SPP_CTRL_ADDR, 1'b1, 32'h100);
        u_spp_term.send(SPP_SPACE_CODE, 120);
        xfer(SPP_FULL_ADDR, 1'b0, 32'h0);
        near(rd, 32'd120);
        xfer(SPP_MASK_ADDR, 1'b1, 32'h5a);
        tx(120, 9'h15a, 1'b1);
        $display("test rerate done");
        summarize();
    end
endmodule
bind spp_top spp_asserts u_spp_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_out_pin(serial_out_pin));
